/* include/ufc_pkg.sv */
package ufc_pkg;

   // register word indices, decoded from haddr_i[7:2], one aligned word each
   localparam logic [5:0] IDX_DATA = 6'h00;
   localparam logic [5:0] IDX_STATUS = 6'h01;
   localparam logic [5:0] IDX_CTRLB = 6'h02;
   localparam logic [5:0] IDX_FFC = 6'h03;
   localparam logic [5:0] IDX_BDL = 6'h04;
   localparam logic [5:0] IDX_BDH = 6'h05;
   localparam logic [5:0] IDX_MASK = 6'h06;

   // frame_format_control fields
   localparam int FFC_MODE_LSB = 6;
   localparam int FFC_PAR_LSB = 4;
   localparam int FFC_STOP_BIT = 3;
   localparam int FFC_SIZE_LSB = 1;
   localparam int FFC_POL_BIT = 0;
   localparam logic [7:0] FFC_RESET = 8'h06;

   // port_control_register_b fields
   localparam int CTRLB_RXEN_BIT = 4;
   localparam int CTRLB_TXEN_BIT = 3;
   localparam int CTRLB_SIZE_TOP_BIT = 2;
   localparam int CTRLB_DBL_BIT = 1;
   localparam logic [7:0] CTRLB_WMASK = 8'h1e;
   localparam logic [7:0] CTRLB_RESET = 8'h00;

   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [3:0] STATUS_RESET = 4'h0;

   // port_status_register bits; 3:0 sticky, 5:4 live
   localparam int ST_RX_DONE = 0;
   localparam int ST_TX_DONE = 1;
   localparam int ST_PARITY = 2;
   localparam int ST_FRAME = 3;
   localparam int ST_TX_BUSY = 4;
   localparam int ST_TX_FULL = 5;

   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SYNC = 2'h1;
   localparam logic [1:0] MODE_RSVD = 2'h2;
   localparam logic [1:0] MODE_SPI = 2'h3;

   localparam logic [1:0] PAR_OFF = 2'h0;
   localparam logic [1:0] PAR_RSVD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;

   localparam logic [4:0] OS_NORMAL = 5'h10;
   localparam logic [4:0] OS_DOUBLE = 5'h08;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b011,
      TX_PARITY = 3'b010,
      TX_STOP1 = 3'b110,
      TX_STOP2 = 3'b111
   } ufc_tx_st_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b011,
      RX_PARITY = 3'b010,
      RX_STOP = 3'b110
   } ufc_rx_st_t;

   function automatic logic [4:0] ufc_os_len(input logic dbl);
      ufc_os_len = dbl ? OS_DOUBLE : OS_NORMAL;
   endfunction

   // reserved codes fall back to eight bits
   function automatic logic [3:0] ufc_char_len(input logic [2:0] code);
      case (code)
         3'h0: ufc_char_len = 4'h5;
         3'h1: ufc_char_len = 4'h6;
         3'h2: ufc_char_len = 4'h7;
         3'h7: ufc_char_len = 4'h9;
         default: ufc_char_len = 4'h8;
      endcase
   endfunction

   // parity bit that makes the frame even, or odd when odd is set
   function automatic logic ufc_parity(input logic [8:0] d, input logic [3:0] len,
                                       input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < len) begin
            p = p ^ d[i];
         end
      end
      ufc_parity = p;
   endfunction

endpackage

/* rtl/ufc_baud.sv */
`timescale 1ns/1ps
module ufc_baud import ufc_pkg::*; (
   input wire logic core_clk_i,         // system clock
   input wire logic resetn_i,           // async reset, active low
   input wire logic [11:0] divisor_i,   // baud_divisor_value
   input wire logic reload_i,           // reload prescaler now
   input wire logic double_i,           // double speed in effect
   output logic presc_tick_o,           // one pulse per div+1 clocks
   output logic bit_tick_o              // one pulse per bit period
);

   logic [11:0] presc_r, presc_nxt;
   logic [4:0] os_r, os_nxt;
   logic tick_r, tick_nxt;
   logic bit_r, bit_nxt;

   always_comb begin
      presc_nxt = presc_r;
      os_nxt = os_r;
      tick_nxt = 1'b0;
      bit_nxt = 1'b0;
      if (reload_i) begin
         presc_nxt = divisor_i;
         os_nxt = 5'h00;
      end else if (presc_r == 12'h000) begin
         // period is divisor plus one clocks per tick
         presc_nxt = divisor_i;
         tick_nxt = 1'b1;
         if (os_r == ufc_os_len(double_i) - 5'h01) begin
            os_nxt = 5'h00;
            bit_nxt = 1'b1;
         end else begin
            os_nxt = os_r + 5'h01;
         end
      end else begin
         presc_nxt = presc_r - 12'h001;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         presc_r <= BAUD_RESET;
         os_r <= 5'h00;
         tick_r <= 1'b0;
         bit_r <= 1'b0;
      end else begin
         presc_r <= presc_nxt;
         os_r <= os_nxt;
         tick_r <= tick_nxt;
         bit_r <= bit_nxt;
      end
   end

   assign presc_tick_o = tick_r;
   assign bit_tick_o = bit_r;

endmodule

/* rtl/ufc_top.sv */
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module ufc_top import ufc_pkg::*; (
   input wire logic core_clk_i,             // system clock, 250 MHz
   input wire logic resetn_i,               // async reset, active low
   input wire logic hsel_i,                 // ahb slave select
   input wire logic [31:0] haddr_i,         // ahb address
   input wire logic [1:0] htrans_i,         // ahb transfer type
   input wire logic hwrite_i,               // ahb write
   input wire logic [2:0] hsize_i,          // ahb size
   input wire logic [31:0] hwdata_i,        // ahb write data
   input wire logic hready_i,               // ahb bus ready
   output logic [31:0] hrdata_o,            // ahb read data
   output logic hreadyout_o,                // ahb slave ready
   output logic hresp_o,                    // ahb response, always okay
   input wire logic receive_pin_i,          // serial data in
   output logic transmit_pin_o,             // serial data out
   output logic sync_clock_pin_o,           // synchronous clock out
   output logic sync_clock_pin_oe_o,        // synchronous clock drive enable
   output logic master_spi_operation_o,     // master spi mode selected
   output logic irq_o                       // level interrupt
);

   // bus and register state
   logic ph_valid_r, ph_valid_nxt;
   logic ph_write_r, ph_write_nxt;
   logic ph_word_r, ph_word_nxt;
   logic [5:0] ph_idx_r, ph_idx_nxt;
   logic ready_r, ready_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] ffc_r, ffc_nxt;
   logic [7:0] ctrlb_r, ctrlb_nxt;
   logic [11:0] baud_r, baud_nxt;
   logic [3:0] mask_r, mask_nxt;
   logic [3:0] status_r, status_nxt;
   logic [8:0] tx_buf_r, tx_buf_nxt;
   logic tx_full_r, tx_full_nxt;
   logic irq_r, irq_nxt;
   logic baud_reload;
   logic wr_en;
   logic rd_en;

   // transmitter state
   ufc_tx_st_t tx_st_r, tx_st_nxt;
   logic [8:0] tx_sh_r, tx_sh_nxt;
   logic [3:0] tx_cnt_r, tx_cnt_nxt;
   logic tx_par_r, tx_par_nxt;
   logic txd_r, txd_nxt;
   logic tx_load;
   logic tx_done;
   logic tx_step;

   // receiver state
   ufc_rx_st_t rx_st_r, rx_st_nxt;
   logic [8:0] rx_sh_r, rx_sh_nxt;
   logic [8:0] rx_data_r, rx_data_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt;
   logic [4:0] rx_os_r, rx_os_nxt;
   logic rx_par_r, rx_par_nxt;
   logic rx_done;
   logic rx_par_err;
   logic rx_frm_err;
   logic rx_mid;
   logic rx_full;
   logic rx_samp;

   // pin side state
   logic xck_r, xck_nxt;
   logic xck_oe_r, xck_oe_nxt;
   logic spi_r, spi_nxt;
   logic rise_ev;
   logic fall_ev;
   logic launch_ev;
   logic sample_ev;

   logic presc_tick;
   logic bit_tick;

   // decoded configuration
   logic [1:0] mode;
   logic [1:0] par_mode;
   logic par_en;
   logic par_odd;
   logic two_stop;
   logic [3:0] char_len;
   logic sync_mode;
   logic mode_ok;
   logic dbl_eff;
   logic [4:0] os_len;

   always_comb begin
      mode = ffc_r[FFC_MODE_LSB +: 2];
      sync_mode = (mode == MODE_SYNC) || (mode == MODE_SPI);
      mode_ok = (mode != MODE_RSVD);
      par_mode = ffc_r[FFC_PAR_LSB +: 2];
      // reserved parity code behaves as parity off
      par_en = (par_mode == PAR_EVEN) || (par_mode == PAR_ODD);
      par_odd = (par_mode == PAR_ODD);
      two_stop = ffc_r[FFC_STOP_BIT];
      char_len = ufc_char_len({ctrlb_r[CTRLB_SIZE_TOP_BIT],
                               ffc_r[FFC_SIZE_LSB +: 2]});
      // double speed has no meaning for the clocked modes
      dbl_eff = ctrlb_r[CTRLB_DBL_BIT] && (mode == MODE_ASYNC);
      os_len = ufc_os_len(dbl_eff);
   end

   ufc_baud u_baud (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .divisor_i(baud_nxt), // the value being written, so a low write reloads with it
      .reload_i(baud_reload),
      .double_i(dbl_eff),
      .presc_tick_o(presc_tick),
      .bit_tick_o(bit_tick)
   );

   // ahb slave: writes take no wait, reads one wait so a write just before is seen
   always_comb begin
      ph_valid_nxt = hsel_i && htrans_i[1] && hready_i;
      ph_write_nxt = ph_write_r;
      ph_word_nxt = ph_word_r;
      ph_idx_nxt = ph_idx_r;
      if (ph_valid_nxt) begin
         ph_write_nxt = hwrite_i;
         ph_word_nxt = (hsize_i == HSIZE_WORD);
         ph_idx_nxt = haddr_i[7:2];
      end
      wr_en = ph_valid_r && ph_write_r && ph_word_r;
      rd_en = ph_valid_r && !ph_write_r;
      ready_nxt = !(ph_valid_nxt && !hwrite_i);
      rdata_nxt = rdata_r;
      if (rd_en) begin
         unique case (ph_idx_r)
            IDX_DATA: rdata_nxt = {23'h00_0000, rx_data_r};
            IDX_STATUS: rdata_nxt = {26'h000_0000, tx_full_r, tx_st_r != TX_IDLE, status_r};
            IDX_CTRLB: rdata_nxt = {24'h00_0000, ctrlb_r};
            IDX_FFC: rdata_nxt = {24'h00_0000, ffc_r};
            IDX_BDL: rdata_nxt = {24'h00_0000, baud_r[7:0]};
            IDX_BDH: rdata_nxt = {28'h000_0000, baud_r[11:8]};
            IDX_MASK: rdata_nxt = {28'h000_0000, mask_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_word_r <= 1'b0;
         ph_idx_r <= 6'h00;
         ready_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         ph_valid_r <= ph_valid_nxt;
         ph_write_r <= ph_write_nxt;
         ph_word_r <= ph_word_nxt;
         ph_idx_r <= ph_idx_nxt;
         ready_r <= ready_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // register file, status and interrupt
   always_comb begin
      ffc_nxt = ffc_r;
      ctrlb_nxt = ctrlb_r;
      baud_nxt = baud_r;
      mask_nxt = mask_r;
      tx_buf_nxt = tx_buf_r;
      tx_full_nxt = tx_full_r && !tx_load;
      baud_reload = 1'b0;
      if (wr_en) begin
         unique case (ph_idx_r)
            IDX_DATA: begin
               // a write while the holding register is full is dropped
               if (!tx_full_r) begin
                  tx_buf_nxt = hwdata_i[8:0];
                  tx_full_nxt = 1'b1;
               end
            end
            IDX_CTRLB: ctrlb_nxt = hwdata_i[7:0] & CTRLB_WMASK;
            IDX_FFC: ffc_nxt = hwdata_i[7:0];
            IDX_BDL: begin
               baud_nxt[7:0] = hwdata_i[7:0];
               baud_reload = 1'b1;
            end
            // upper nibble is not stored and reads back zero
            IDX_BDH: baud_nxt[11:8] = hwdata_i[3:0];
            IDX_MASK: mask_nxt = hwdata_i[3:0];
            default: begin
            end
         endcase
      end
      // a new event in the clearing read cycle survives
      status_nxt = status_r;
      if (rd_en && ph_idx_r == IDX_STATUS) begin
         status_nxt = STATUS_RESET;
      end
      status_nxt[ST_RX_DONE] = status_nxt[ST_RX_DONE] | rx_done;
      status_nxt[ST_TX_DONE] = status_nxt[ST_TX_DONE] | tx_done;
      status_nxt[ST_PARITY] = status_nxt[ST_PARITY] | rx_par_err;
      status_nxt[ST_FRAME] = status_nxt[ST_FRAME] | rx_frm_err;
      irq_nxt = |(status_nxt & mask_nxt);
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ffc_r <= FFC_RESET;
         ctrlb_r <= CTRLB_RESET;
         baud_r <= BAUD_RESET;
         mask_r <= MASK_RESET;
         status_r <= STATUS_RESET;
         tx_buf_r <= 9'h000;
         tx_full_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         ffc_r <= ffc_nxt;
         ctrlb_r <= ctrlb_nxt;
         baud_r <= baud_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         tx_buf_r <= tx_buf_nxt;
         tx_full_r <= tx_full_nxt;
         irq_r <= irq_nxt;
      end
   end

   // synchronous clock pin and the edges it defines
   always_comb begin
      rise_ev = sync_mode && presc_tick && !xck_r;
      fall_ev = sync_mode && presc_tick && xck_r;
      launch_ev = ffc_r[FFC_POL_BIT] ? fall_ev : rise_ev;
      sample_ev = ffc_r[FFC_POL_BIT] ? rise_ev : fall_ev;
      xck_nxt = sync_mode && (xck_r ^ presc_tick);
      xck_oe_nxt = sync_mode;
      spi_nxt = (mode == MODE_SPI);
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xck_r <= 1'b0;
         xck_oe_r <= 1'b0;
         spi_r <= 1'b0;
      end else begin
         xck_r <= xck_nxt;
         xck_oe_r <= xck_oe_nxt;
         spi_r <= spi_nxt;
      end
   end

   // transmitter
   always_comb begin
      tx_step = sync_mode ? launch_ev : bit_tick;
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_par_nxt = tx_par_r;
      txd_nxt = txd_r;
      tx_load = 1'b0;
      tx_done = 1'b0;
      if (tx_step) begin
         unique case (tx_st_r)
            TX_IDLE: begin
               txd_nxt = 1'b1;
               if (ctrlb_r[CTRLB_TXEN_BIT] && tx_full_r && mode_ok) begin
                  tx_sh_nxt = tx_buf_r;
                  tx_par_nxt = ufc_parity(tx_buf_r, char_len, par_odd);
                  tx_load = 1'b1;
                  txd_nxt = 1'b0;
                  tx_st_nxt = TX_START;
               end
            end
            TX_START: begin
               txd_nxt = tx_sh_r[0];
               tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
               tx_cnt_nxt = 4'h1;
               tx_st_nxt = TX_DATA;
            end
            TX_DATA: begin
               if (tx_cnt_r == char_len) begin
                  txd_nxt = par_en ? tx_par_r : 1'b1;
                  tx_st_nxt = par_en ? TX_PARITY : TX_STOP1;
               end else begin
                  txd_nxt = tx_sh_r[0];
                  tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
                  tx_cnt_nxt = tx_cnt_r + 4'h1;
               end
            end
            TX_PARITY: begin
               txd_nxt = 1'b1;
               tx_st_nxt = TX_STOP1;
            end
            TX_STOP1: begin
               tx_st_nxt = two_stop ? TX_STOP2 : TX_IDLE;
               tx_done = !two_stop;
            end
            TX_STOP2: begin
               tx_st_nxt = TX_IDLE;
               tx_done = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 9'h000;
         tx_cnt_r <= 4'h0;
         tx_par_r <= 1'b0;
         txd_r <= 1'b1;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_par_r <= tx_par_nxt;
         txd_r <= txd_nxt;
      end
   end

   // receiver; async mode oversamples on the prescaler tick
   always_comb begin
      rx_mid = presc_tick && (rx_os_r == (os_len >> 1) - 5'h01);
      rx_full = presc_tick && (rx_os_r == os_len - 5'h01);
      rx_samp = sync_mode ? sample_ev : rx_full;
      rx_st_nxt = rx_st_r;
      rx_sh_nxt = rx_sh_r;
      rx_data_nxt = rx_data_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_par_nxt = rx_par_r;
      rx_os_nxt = rx_os_r;
      rx_done = 1'b0;
      rx_par_err = 1'b0;
      rx_frm_err = 1'b0;
      if (presc_tick) begin
         rx_os_nxt = rx_full ? 5'h00 : rx_os_r + 5'h01;
      end
      unique case (rx_st_r)
         RX_IDLE: begin
            rx_os_nxt = 5'h00;
            rx_cnt_nxt = 4'h0;
            rx_sh_nxt = 9'h000;
            if (ctrlb_r[CTRLB_RXEN_BIT] && mode_ok && !receive_pin_i) begin
               if (sync_mode && sample_ev) begin
                  rx_st_nxt = RX_DATA;
               end else if (!sync_mode && presc_tick) begin
                  rx_os_nxt = 5'h01;
                  rx_st_nxt = RX_START;
               end
            end
         end
         RX_START: begin
            if (rx_mid) begin
               // a start bit gone high again by mid-bit is a glitch
               rx_os_nxt = 5'h00;
               rx_st_nxt = receive_pin_i ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_samp) begin
               rx_sh_nxt[rx_cnt_r] = receive_pin_i;
               rx_cnt_nxt = rx_cnt_r + 4'h1;
               if (rx_cnt_r == char_len - 4'h1) begin
                  rx_st_nxt = par_en ? RX_PARITY : RX_STOP;
               end
            end
         end
         RX_PARITY: begin
            if (rx_samp) begin
               rx_par_nxt = receive_pin_i;
               rx_st_nxt = RX_STOP;
            end
         end
         RX_STOP: begin
            // only the first stop bit is looked at, whatever the stop select
            if (rx_samp) begin
               rx_data_nxt = rx_sh_r;
               rx_done = 1'b1;
               rx_frm_err = !receive_pin_i;
               rx_par_err = par_en &&
                  (ufc_parity(rx_sh_r, char_len, par_odd) != rx_par_r);
               rx_st_nxt = RX_IDLE;
            end
         end
         default: rx_st_nxt = RX_IDLE;
      endcase
      if (!ctrlb_r[CTRLB_RXEN_BIT]) begin
         rx_st_nxt = RX_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_st_r <= RX_IDLE;
         rx_sh_r <= 9'h000;
         rx_data_r <= 9'h000;
         rx_cnt_r <= 4'h0;
         rx_par_r <= 1'b0;
         rx_os_r <= 5'h00;
      end else begin
         rx_st_r <= rx_st_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_data_r <= rx_data_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_par_r <= rx_par_nxt;
         rx_os_r <= rx_os_nxt;
      end
   end

   assign hrdata_o = rdata_r;
   assign hreadyout_o = ready_r;
   assign hresp_o = 1'b0;
   assign transmit_pin_o = txd_r;
   assign sync_clock_pin_o = xck_r;
   assign sync_clock_pin_oe_o = xck_oe_r;
   assign master_spi_operation_o = spi_r;
   assign irq_o = irq_r;

endmodule

/* test/ufc_monitor.sv */
`timescale 1ns/1ps
module ufc_monitor (
   input wire logic core_clk_i, // clock
   input wire logic resetn_i, // reset
   input wire logic hsel_i, // select
   input wire logic [1:0] htrans_i, // trans
   input wire logic hwrite_i, // write
   input wire logic hready_i, // ready in
   input wire logic [31:0] hrdata_o, // rdata
   input wire logic hreadyout_o, // ready out
   input wire logic hresp_o, // resp
   input wire logic transmit_pin_o, // tx
   input wire logic sync_clock_pin_o, // clk pin
   input wire logic sync_clock_pin_oe_o, // clk oe
   input wire logic master_spi_operation_o // spi
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   logic tx_q_r;
   logic tx_edge;
   logic take;
   assign tx_edge = transmit_pin_o != tx_q_r;
   assign take = hsel_i && htrans_i[1] && hready_i;
   // saturates so a long idle line never wraps into a short count
   always_comb begin
      run_nxt = tx_edge ? 8'h00 : run_r + {7'h00, run_r != 8'hff};
   end
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         run_r <= 8'hff;
         tx_q_r <= 1'b1;
      end else begin
         run_r <= run_nxt;
         tx_q_r <= transmit_pin_o;
      end
   end
   spi_oe_a: assert property (master_spi_operation_o |-> sync_clock_pin_oe_o)
      else $error("spi without clock drive");
   clk_idle_a: assert property (!sync_clock_pin_oe_o && !$past(sync_clock_pin_oe_o)
      |-> !sync_clock_pin_o) else $error("clock moves outside sync");
   launch_edge_a: assert property (sync_clock_pin_oe_o && $changed(transmit_pin_o)
      |-> $changed(sync_clock_pin_o)) else $error("data change off clock edge");
   async_bit_a: assert property (tx_edge && !sync_clock_pin_oe_o |-> run_r >= 8'd7)
      else $error("async bit too short");
   read_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait not one cycle");
   write_fast_a: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write stalled");
   rdata_hold_a: assert property (!$rose(hreadyout_o) |-> $stable(hrdata_o))
      else $error("read data moved");
   resp_ok_a: assert property (hreadyout_o |-> !hresp_o)
      else $error("response not okay");
endmodule

/* test/ufc_peer.sv */
`timescale 1ns/1ps
module ufc_peer (
   input wire logic core_clk_i, // clock
   output logic line_o // into receive pin
);
   initial line_o = 1'b1;
   task automatic put(input logic v, input int b);
      line_o <= v;
      repeat (b) @(posedge core_clk_i);
   endtask
   // always one stop bit, so a two-stop receiver setting must not matter
   task automatic send(input logic [8:0] d, input int n, input logic pe, input logic pv,
                       input logic bad_stop, input int b);
      put(1'b0, b);
      for (int i = 0; i < n; i++) put(d[i], b);
      if (pe) put(pv, b);
      put(!bad_stop, b);
      line_o <= 1'b1;
   endtask
endmodule

/* test/ufc_tb_top.sv */
`timescale 1ns/1ps
module ufc_tb_top import ufc_pkg::*; ();
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0000_0000;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = HSIZE_WORD;
   logic [31:0] hwdata_i = 32'h0000_0000;
   wire logic hready_i;
   logic [31:0] hrdata_o;
   logic [31:0] rv;
   logic hreadyout_o, hresp_o, receive_pin_i, transmit_pin_o, irq_o;
   logic sync_clock_pin_o, sync_clock_pin_oe_o, master_spi_operation_o;
   logic [15:0] txt [5] = '{16'h2013, 16'hffa5, 16'h463c, 16'hb22d, 16'h1455};
   logic [15:0] rxt [3] = '{16'h26a7, 16'h7435, 16'h8fc3};
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   assign hready_i = hreadyout_o;
   always #2 core_clk_i = ~core_clk_i;
   ufc_top dut_u (.*);
   ufc_peer peer_u (.core_clk_i(core_clk_i), .line_o(receive_pin_i));
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel_i <= 1'b1;
      haddr_i <= {24'h00_0000, a};
      htrans_i <= 2'h2;
      hwrite_i <= w;
      @(posedge core_clk_i);
      while (!hready_i) @(posedge core_clk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge core_clk_i);
      while (!hready_i) @(posedge core_clk_i);
      rv = hrdata_o;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(nm, rv, e);
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? sync_clock_pin_o : s == 1 ? transmit_pin_o : irq_o;
   endfunction
   task automatic wait_sig(input int s, input logic v, output int n);
      n = 0;
      while (pick(s) !== v && n < 4000) begin
         @(posedge core_clk_i);
         n++;
      end
   endtask
   initial begin
      logic [15:0] f;
      logic [15:0] fr;
      logic [8:0] dm;
      logic pb;
      int n, b, nb, t0, k;
      repeat (2) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      rdc("ffc", 8'h0c, 32'h0000_0006);
      rdc("ctrlb", 8'h08, 32'h0000_0000);
      rdc("unmapped", 8'h1c, 32'h0000_0000);
      xfer(8'h14, 1'b1, 32'h0000_000a);
      xfer(8'h10, 1'b1, 32'h0000_005c);
      rdc("bdh", 8'h14, 32'h0000_000a);
      rdc("bdl", 8'h10, 32'h0000_005c);
      for (k = 0; k < 4; k++) begin
         xfer(8'h0c, 1'b1, 32'(k) << 6);
         repeat (2) @(posedge core_clk_i);
         chk("spi", master_spi_operation_o, k == 3);
         chk("clk_oe", sync_clock_pin_oe_o, k[0]);
      end
      xfer(8'h14, 1'b1, 32'h0000_0000);
      xfer(8'h10, 1'b1, 32'h0000_0001);
      wait_sig(0, !sync_clock_pin_o, n);
      chk("reload", n < 8, 1'b1);
      xfer(8'h08, 1'b1, 32'h0000_0018);
      for (k = 0; k < 2; k++) begin
         xfer(8'h0c, 1'b1, 32'h0000_0046 | 32'(k));
         wait_sig(0, !sync_clock_pin_o, n);
         wait_sig(0, !sync_clock_pin_o, n);
         chk("clk_half", n, 2);
         xfer(8'h00, 1'b1, 32'h0000_0055);
         t0 = 0;
         pb = transmit_pin_o;
         repeat (120) begin
            @(posedge core_clk_i);
            if (transmit_pin_o !== pb) begin
               t0++;
               chk("launch", sync_clock_pin_o, !k[0]);
            end
            pb = transmit_pin_o;
         end
         chk("sync_frame", t0 > 0, 1'b1);
      end
      xfer(8'h0c, 1'b1, 32'h0000_0000);
      xfer(8'h18, 1'b1, 32'h0000_0002);
      xfer(8'h04, 1'b0, 32'h0000_0000);
      for (k = 0; k < 8; k++) begin
         f = k < 5 ? txt[k] : rxt[k - 5];
         n = f[11:9] == 3'h7 ? 9 : int'(f[11:9]) + 5;
         dm = f[8:0] & 9'((1 << n) - 1);
         if (k == 5) xfer(8'h18, 1'b1, 32'h0000_0001);
         if (k >= 5) begin
            xfer(8'h08, 1'b1, {24'h00_0000, 3'h0, 2'b11, f[11], 2'b00});
            xfer(8'h0c, 1'b1, {24'h00_0000, 2'b00, f[13:12], 1'b1, f[10:9], 1'b0});
            peer_u.send(f[8:0], n, f[13], ^dm ^ f[12] ^ f[14], f[15], 32);
            repeat (8) @(posedge core_clk_i);
            chk("rx_irq", irq_o, 1'b1);
            xfer(8'h04, 1'b0, 32'h0000_0000);
            chk("rx_status", rv[3:0], {f[15], f[14], 2'b01});
            rdc("rx_data", 8'h00, {23'h00_0000, dm});
            continue;
         end
         b = f[15] ? 16 : 32;
         fr = 16'hffff;
         fr[0] = 1'b0;
         for (int j = 0; j < n; j++) fr[1 + j] = dm[j];
         if (f[13]) fr[n + 1] = ^dm ^ f[12];
         nb = 2 + n + int'(f[13]) + int'(f[14]);
         xfer(8'h08, 1'b1, {24'h00_0000, 3'h0, 2'b11, f[11], f[15], 1'b0});
         xfer(8'h0c, 1'b1, {24'h00_0000, 2'b00, f[13:12], f[14], f[10:9], 1'b0});
         xfer(8'h00, 1'b1, {23'h00_0000, dm});
         wait_sig(1, 1'b0, t0);
         t0 = cyc;
         repeat (b / 2) @(posedge core_clk_i);
         for (int j = 0; j < nb; j++) begin
            chk("tx_bit", transmit_pin_o, fr[j]);
            if (j < nb - 1) repeat (b) @(posedge core_clk_i);
         end
         wait_sig(2, 1'b1, n);
         n = cyc - t0;
         chk("frame_len", n >= nb * b - 2 && n <= nb * b + 3, 1'b1);
         xfer(8'h04, 1'b0, 32'h0000_0000);
         chk("tx_done", rv[3:0], 4'h2);
         repeat (2) @(posedge core_clk_i);
         chk("irq_clear", irq_o, 1'b0);
      end
      conclude();
   end
endmodule
bind ufc_top ufc_monitor mon_u (.*);
